//--- hw/boot_phase_pin_function_switch.sv
`timescale 1ns/1ps
// Overview of operation
// - after reset, volume pin is serial data: master input or slave output.
// - once firmware runs, volume pin becomes volume pulse input.
// - after reset, temperature pin is serial data: master output or slave input.
// - once firmware runs, temperature pin becomes board temperature input.
// - audio transmit floats during reset, carries stream in operation.
// - boot straps sampled at reset release select the boot mode.
// - error/config pin is an input strap during reset.
// - once firmware runs, error/config pin drives low on amplifier fault.
// - second config strap is input in reset, then supply sync output.
module boot_phase_pin_function_switch
	import pin_switch_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic fw_running,
	input wire logic spi_is_master,
	input wire logic spi_mosi_out,
	input wire logic spi_miso_out,
	output logic spi_miso_in,
	output logic spi_mosi_in,
	input wire logic vol_pin_i,
	output logic vol_pin_o,
	output logic vol_pin_oe,
	input wire logic temp_pin_i,
	output logic temp_pin_o,
	output logic temp_pin_oe,
	output logic volume_pulse_in,
	output logic board_thermal_in,
	input wire logic audio_tx_data,
	output logic digital_audio_tx,
	output logic digital_audio_tx_oe,
	input wire logic boot_strap_a,
	input wire logic boot_strap_b,
	input wire logic err_pin_i,
	output logic amp_fault_out_n,
	output logic err_pin_oe,
	input wire logic sync_pin_i,
	output logic supply_sync_out,
	output logic sync_pin_oe,
	input wire logic amp_fault,
	input wire logic supply_sync,
	output logic [1:0] boot_mode,
	output logic [1:0] amp_config,
	output logic straps_valid,
	output logic run_phase
);
	strap_if straps ();
	pin_phase_e phase_r, phase_nxt;
	logic vol_o_r, vol_o_nxt, vol_oe_r, vol_oe_nxt;
	logic tmp_o_r, tmp_o_nxt, tmp_oe_r, tmp_oe_nxt;
	logic miso_in_r, miso_in_nxt, mosi_in_r, mosi_in_nxt;
	logic volp_r, volp_nxt, therm_r, therm_nxt;
	logic atx_r, atx_nxt, atx_oe_r, atx_oe_nxt;
	logic err_r, err_nxt, err_oe_r, err_oe_nxt;
	logic syn_r, syn_nxt, syn_oe_r, syn_oe_nxt;

	strap_capture u_cap (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.boot_strap_a(boot_strap_a),
		.boot_strap_b(boot_strap_b),
		.amp_config_strap0(err_pin_i),
		.amp_config_strap1(sync_pin_i),
		.straps(straps)
	);

	// phase: enters run once, leaves only through reset
	always_comb begin
		phase_nxt = phase_r;
		case (phase_r)
			PHASE_BOOT: if (fw_running && straps.captured) phase_nxt = PHASE_RUN;
			PHASE_RUN: phase_nxt = PHASE_RUN;
			default: phase_nxt = PHASE_BOOT;
		endcase
	end

	// pin routing for both phases
	always_comb begin
		vol_o_nxt = 1'b0;
		vol_oe_nxt = 1'b0;
		tmp_o_nxt = 1'b0;
		tmp_oe_nxt = 1'b0;
		miso_in_nxt = 1'b0;
		mosi_in_nxt = 1'b0;
		volp_nxt = volp_r;
		therm_nxt = therm_r;
		err_nxt = FAULT_IDLE;
		err_oe_nxt = 1'b0;
		syn_nxt = 1'b0;
		syn_oe_nxt = 1'b0;
		atx_nxt = audio_tx_data;
		atx_oe_nxt = 1'b1;
		if (phase_nxt == PHASE_BOOT) begin
			if (spi_is_master) begin
				miso_in_nxt = vol_pin_i;
				tmp_o_nxt = spi_mosi_out;
				tmp_oe_nxt = 1'b1;
			end else begin
				vol_o_nxt = spi_miso_out;
				vol_oe_nxt = 1'b1;
				mosi_in_nxt = temp_pin_i;
			end
		end else begin
			volp_nxt = vol_pin_i;
			therm_nxt = temp_pin_i;
			err_nxt = !amp_fault;
			err_oe_nxt = 1'b1;
			syn_nxt = supply_sync;
			syn_oe_nxt = 1'b1;
		end
	end

	// register pins; reset leaves every driver off (straps as inputs)
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			phase_r <= PHASE_BOOT;
			vol_o_r <= 1'b0;
			vol_oe_r <= 1'b0;
			tmp_o_r <= 1'b0;
			tmp_oe_r <= 1'b0;
			miso_in_r <= 1'b0;
			mosi_in_r <= 1'b0;
			volp_r <= 1'b0;
			therm_r <= 1'b0;
			atx_r <= 1'b0;
			atx_oe_r <= 1'b0;
			err_r <= FAULT_IDLE;
			err_oe_r <= 1'b0;
			syn_r <= 1'b0;
			syn_oe_r <= 1'b0;
		end else begin
			phase_r <= phase_nxt;
			vol_o_r <= vol_o_nxt;
			vol_oe_r <= vol_oe_nxt;
			tmp_o_r <= tmp_o_nxt;
			tmp_oe_r <= tmp_oe_nxt;
			miso_in_r <= miso_in_nxt;
			mosi_in_r <= mosi_in_nxt;
			volp_r <= volp_nxt;
			therm_r <= therm_nxt;
			atx_r <= atx_nxt;
			atx_oe_r <= atx_oe_nxt;
			err_r <= err_nxt;
			err_oe_r <= err_oe_nxt;
			syn_r <= syn_nxt;
			syn_oe_r <= syn_oe_nxt;
		end
	end

	assign vol_pin_o = vol_o_r;
	assign vol_pin_oe = vol_oe_r;
	assign temp_pin_o = tmp_o_r;
	assign temp_pin_oe = tmp_oe_r;
	assign spi_miso_in = miso_in_r;
	assign spi_mosi_in = mosi_in_r;
	assign volume_pulse_in = volp_r;
	assign board_thermal_in = therm_r;
	assign digital_audio_tx = atx_r;
	assign digital_audio_tx_oe = atx_oe_r;
	assign amp_fault_out_n = err_r;
	assign err_pin_oe = err_oe_r;
	assign supply_sync_out = syn_r;
	assign sync_pin_oe = syn_oe_r;
	assign boot_mode = straps.boot_mode;
	assign amp_config = straps.amp_config;
	assign straps_valid = straps.captured;
	assign run_phase = (phase_r == PHASE_RUN);

	// checks: phase stickiness and entry
	chk_run_sticky: assert property (
		@(posedge core_clk) disable iff (!rst_n) run_phase |=> run_phase)
		else $error("run phase left without reset");
	chk_run_entry: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(!run_phase && fw_running && straps_valid) |=> run_phase)
		else $error("run phase not entered");

	// checks: error/config pin
	chk_fault_low: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(run_phase && amp_fault) |=> (!amp_fault_out_n && err_pin_oe))
		else $error("fault not driven low");
	chk_fault_idle: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(run_phase && !amp_fault) |=> (amp_fault_out_n && err_pin_oe))
		else $error("fault output not idle high");
	chk_cfg_input: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		!run_phase |-> (!err_pin_oe && !sync_pin_oe))
		else $error("strap pin driven in boot phase");

	// checks: supply sync pin
	chk_sync_out: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		run_phase |-> (sync_pin_oe && !vol_pin_oe && !temp_pin_oe))
		else $error("run phase pin direction wrong");
	chk_sync_follow: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		run_phase |=> (supply_sync_out == $past(supply_sync)))
		else $error("supply sync not followed");

	// checks: boot-phase serial data routing
	chk_miso_slave: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(!run_phase && !spi_is_master && !fw_running) |=> vol_pin_oe)
		else $error("slave miso not driven");
	chk_miso_master: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(!run_phase && spi_is_master && !fw_running) |=> (spi_miso_in == $past(vol_pin_i)))
		else $error("master miso not sampled");
	chk_mosi_master: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(!run_phase && spi_is_master && !fw_running) |=> (temp_pin_oe && !vol_pin_oe))
		else $error("master mosi not driven");
	chk_mosi_slave: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(!run_phase && !spi_is_master && !fw_running) |=> (spi_mosi_in == $past(temp_pin_i)))
		else $error("slave mosi not sampled");

	// checks: run-phase monitor inputs
	chk_vol_follow: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(run_phase ##1 run_phase) |-> volume_pulse_in == $past(vol_pin_i))
		else $error("volume input not followed");
	chk_thermal: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		(run_phase ##1 run_phase) |-> board_thermal_in == $past(temp_pin_i))
		else $error("thermal input not followed");

	// checks: audio transmit pin
	chk_tx_float: assert property (
		@(posedge core_clk) !rst_n |=> !digital_audio_tx_oe)
		else $error("audio tx driven in reset");
	chk_tx_follow: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		rst_n |=> (digital_audio_tx_oe && digital_audio_tx == $past(audio_tx_data)))
		else $error("audio tx not carried");

	// checks: captured straps hold
	chk_mode_hold: assert property (
		@(posedge core_clk) disable iff (!rst_n) straps_valid |=> $stable(boot_mode))
		else $error("boot mode changed");
	chk_cfg_hold: assert property (
		@(posedge core_clk) disable iff (!rst_n) straps_valid |=> $stable(amp_config))
		else $error("amplifier config changed");

	// main scenarios
	cov_run: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(run_phase));
	cov_fault: cover property (@(posedge core_clk) disable iff (!rst_n)
		run_phase && !amp_fault_out_n);
	cov_slave: cover property (@(posedge core_clk) disable iff (!rst_n)
		!run_phase && vol_pin_oe);
	cov_master: cover property (@(posedge core_clk) disable iff (!rst_n)
		!run_phase && temp_pin_oe);
	cov_refused: cover property (@(posedge core_clk) disable iff (!rst_n)
		run_phase && !fw_running);
endmodule

//--- inc/pin_switch_pkg.sv
package pin_switch_pkg;
	// boot modes from the two boot straps {b,a}
	typedef enum logic [1:0] {
		BOOT_MODE_0,
		BOOT_MODE_1,
		BOOT_MODE_2,
		BOOT_MODE_3
	} boot_mode_e;
	// pin phase
	typedef enum logic {
		PHASE_BOOT,
		PHASE_RUN
	} pin_phase_e;
	localparam logic [1:0] STRAP_RESET = 2'h0;
	localparam logic FAULT_IDLE = 1'h1;
endpackage

//--- inc/strap_if.sv
`timescale 1ns/1ps
// strap capture results passed from the capture unit to the top
interface strap_if;
	logic [1:0] boot_mode;
	logic [1:0] amp_config;
	logic captured;
	modport capture (output boot_mode, output amp_config, output captured);
	modport user (input boot_mode, input amp_config, input captured);
endinterface

//--- hw/strap_capture.sv
`timescale 1ns/1ps
module strap_capture
	import pin_switch_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic boot_strap_a,
	input wire logic boot_strap_b,
	input wire logic amp_config_strap0,
	input wire logic amp_config_strap1,
	strap_if.capture straps
);
	logic [1:0] boot_r, boot_nxt;
	logic [1:0] cfg_r, cfg_nxt;
	logic done_r, done_nxt;

	// catch straps on the first clock after reset release, then hold
	always_comb begin
		boot_nxt = boot_r;
		cfg_nxt = cfg_r;
		done_nxt = done_r;
		if (!done_r) begin
			boot_nxt = {boot_strap_b, boot_strap_a};
			cfg_nxt = {amp_config_strap1, amp_config_strap0};
			done_nxt = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			boot_r <= STRAP_RESET;
			cfg_r <= STRAP_RESET;
			done_r <= 1'b0;
		end else begin
			boot_r <= boot_nxt;
			cfg_r <= cfg_nxt;
			done_r <= done_nxt;
		end
	end

	assign straps.boot_mode = boot_r;
	assign straps.amp_config = cfg_r;
	assign straps.captured = done_r;
endmodule

//--- tb/board_model.sv
`timescale 1ns/1ps
// board straps, boot memory and sensors as seen from the pins
module board_model (
	input wire logic [3:0] strap_set,
	input wire logic vol_src,
	input wire logic temp_src,
	input wire logic vol_o,
	input wire logic vol_oe,
	input wire logic temp_o,
	input wire logic temp_oe,
	input wire logic err_o,
	input wire logic err_oe,
	input wire logic sync_o,
	input wire logic sync_oe,
	output logic boot_strap_a,
	output logic boot_strap_b,
	output logic err_pin_i,
	output logic sync_pin_i,
	output logic vol_pin_i,
	output logic temp_pin_i
);
	// boot straps follow strap_set[1:0] as the bench sets them
	assign boot_strap_a = strap_set[0];
	assign boot_strap_b = strap_set[1];
	// config pins read the pull level unless the device drives
	assign err_pin_i = err_oe ? err_o : strap_set[2];
	assign sync_pin_i = sync_oe ? sync_o : strap_set[3];
	// memory or sensor drives whenever the device does not
	assign vol_pin_i = vol_oe ? vol_o : vol_src;
	assign temp_pin_i = temp_oe ? temp_o : temp_src;
endmodule

//--- tb/boot_phase_pin_function_switch_bench.sv
`timescale 1ns/1ps
module boot_phase_pin_function_switch_bench;
	import pin_switch_pkg::*;
	logic core_clk, rst_n, fw_running, spi_is_master, spi_mosi_out, spi_miso_out;
	logic spi_miso_in, spi_mosi_in, vol_pin_i, vol_pin_o, vol_pin_oe, temp_pin_i;
	logic temp_pin_o, temp_pin_oe, volume_pulse_in, board_thermal_in, audio_tx_data;
	logic digital_audio_tx, digital_audio_tx_oe, boot_strap_a, boot_strap_b, err_pin_i;
	logic amp_fault_out_n, err_pin_oe, sync_pin_i, supply_sync_out, sync_pin_oe;
	logic amp_fault, supply_sync, straps_valid, run_phase, vol_src, temp_src;
	logic [1:0] boot_mode, amp_config;
	logic [3:0] strap_set;
	int err_count, samples_checked;
	boot_phase_pin_function_switch boot_phase_pin_function_switch_i (.core_clk, .rst_n,
		.fw_running, .spi_is_master, .spi_mosi_out, .spi_miso_out, .spi_miso_in,
		.spi_mosi_in, .vol_pin_i, .vol_pin_o, .vol_pin_oe, .temp_pin_i, .temp_pin_o,
		.temp_pin_oe, .volume_pulse_in, .board_thermal_in, .audio_tx_data, .digital_audio_tx,
		.digital_audio_tx_oe, .boot_strap_a, .boot_strap_b, .err_pin_i, .amp_fault_out_n,
		.err_pin_oe, .sync_pin_i, .supply_sync_out, .sync_pin_oe, .amp_fault, .supply_sync,
		.boot_mode, .amp_config, .straps_valid, .run_phase);
	board_model board_model_i (.strap_set, .vol_src, .temp_src, .vol_o(vol_pin_o),
		.vol_oe(vol_pin_oe), .temp_o(temp_pin_o), .temp_oe(temp_pin_oe),
		.err_o(amp_fault_out_n), .err_oe(err_pin_oe), .sync_o(supply_sync_out),
		.sync_oe(sync_pin_oe), .boot_strap_a, .boot_strap_b, .err_pin_i, .sync_pin_i,
		.vol_pin_i, .temp_pin_i);
	// clock generator
	always #12.5 core_clk = ~core_clk;
	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [1:0] got, input logic [1:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// reset with given straps, then check float and capture
	task automatic do_reset(input logic [3:0] s);
		rst_n = 1'b0;
		fw_running = 1'b0;
		strap_set = s;
		repeat (8) @(negedge core_clk);
		chk_bit(digital_audio_tx_oe, 1'b0);
		chk({err_pin_oe, sync_pin_oe}, 2'h0);
		chk_bit(amp_fault_out_n, 1'b1);
		rst_n = 1'b1;
		repeat (2) @(negedge core_clk);
		strap_set = ~s;
		@(negedge core_clk);
		chk(boot_mode, s[1:0]);
		chk(amp_config, s[3:2]);
		chk({straps_valid, run_phase}, 2'h2);
		chk_bit(digital_audio_tx_oe, 1'b1);
	endtask
	// boot routing of both data pins, master and slave
	task automatic boot_route();
		logic d;
		for (int k = 0; k < 4; k++) begin
			d = k[0];
			spi_is_master = k[1];
			{vol_src, temp_src, spi_mosi_out, spi_miso_out, audio_tx_data} = {d, ~d, d, ~d, d};
			repeat (2) @(negedge core_clk);
			chk_bit(digital_audio_tx, d);
			chk({err_pin_oe, sync_pin_oe}, 2'h0);
			if (k[1]) begin
				chk({vol_pin_oe, spi_miso_in}, {1'b0, d});
				chk({temp_pin_oe, temp_pin_o}, {1'b1, d});
			end else begin
				chk({vol_pin_oe, vol_pin_o}, {1'b1, ~d});
				chk({temp_pin_oe, spi_mosi_in}, {1'b0, ~d});
			end
		end
	endtask
	// switch to run roles and stay there
	task automatic run_switch();
		logic d;
		int n;
		fw_running = 1'b1;
		n = 0;
		while (run_phase !== 1'b1 && n < 4) begin
			@(negedge core_clk);
			n++;
		end
		// bound used up: count it and close the run
		if (n == 4) begin
			err_count++;
			report_and_stop();
		end
		chk(2'(n), 2'h1);
		for (int k = 0; k < 3; k++) begin
			d = k[0];
			{vol_src, temp_src, amp_fault, supply_sync, fw_running} = {d, ~d, d, ~d, k == 0};
			repeat (2) @(negedge core_clk);
			chk({vol_pin_oe, volume_pulse_in}, {1'b0, d});
			chk({temp_pin_oe, board_thermal_in}, {1'b0, ~d});
			chk({err_pin_oe, amp_fault_out_n}, {1'b1, ~d});
			chk({sync_pin_oe, supply_sync_out}, {1'b1, ~d});
			chk_bit(run_phase, 1'b1);
		end
	endtask
	// stimulus at falling edges
	initial begin
		core_clk = 1'b0;
		{spi_is_master, spi_mosi_out, spi_miso_out, audio_tx_data} = 4'h0;
		{amp_fault, supply_sync, vol_src, temp_src} = 4'h0;
		err_count = 0;
		samples_checked = 0;
		for (int i = 0; i < 4; i++) begin
			do_reset({~i[1:0], i[1:0]});
			boot_route();
			run_switch();
		end
		report_and_stop();
	end
	// hang guard
	initial begin
		repeat (3000) @(posedge core_clk);
		err_count++;
		report_and_stop();
	end
endmodule
